// [rtl/csp_defs.svh]
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
// Overview of operation
// R1: The three prescaler select bits pick a serial clock of the system clock over 1024, 256, 64, 32, 16, 8, 4 or 2 for codes 000 to 111.
// R2: With the clock source select cleared, transfers run from the prescaler and the clock pin is driven as an output.
// R3: With the clock source select set, the clock pin is an input and the outside party must supply the transfer clock on it.
// R4: The two mode bits select 8-bit transfer (00), 16-bit transfer (01) or continuous clock output (10), and code 11 is reserved.
// R5: Both data byte registers hold outgoing and incoming data, are readable and writable, and have no defined value after reset.
// R6: In 8-bit mode the upper data byte is left alone and only the lower byte is shifted.
// R7: In 16-bit mode the upper byte is bits 15 to 8 and the lower byte bits 7 to 0 of the shifted word.
// R8: Status flags are cleared only by writing zero to them, and writing one to a flag does nothing; code also clears on a one to the clear offset.
// R9: A software write to the output level control forces the serial data output high; the code ignores that write while a transfer is shifting.
// R10: In continuous clock mode the clock pin keeps toggling at the prescaler rate with no data framing until the mode changes; code: internal clock only.

// Register byte offsets
`define CSP_OFS_MODE      8'h00
`define CSP_OFS_DATA_HI   8'h04
`define CSP_OFS_DATA_LO   8'h08
`define CSP_OFS_CTRL      8'h0c
`define CSP_OFS_STAT      8'h10
`define CSP_OFS_CLR       8'h14
`define CSP_OFS_IEN       8'h18

// Field positions
`define CSP_MODE_OP_HI    7
`define CSP_MODE_OP_LO    6
`define CSP_MODE_SRC      3
`define CSP_CTRL_START    0
`define CSP_CTRL_SO_HIGH  4
`define CSP_ST_DONE       0
`define CSP_ST_COLL       1

// Reset values
`define CSP_MODE_RST      8'h00
`define CSP_IEN_RST       2'h0
`define CSP_STAT_RST      2'h0

// Prescaler half periods less one, in system clocks, for divisors 1024 down to 2
`define CSP_HALF_0        9'h1ff
`define CSP_HALF_1        9'h07f
`define CSP_HALF_2        9'h01f
`define CSP_HALF_3        9'h00f
`define CSP_HALF_4        9'h007
`define CSP_HALF_5        9'h003
`define CSP_HALF_6        9'h001
`define CSP_HALF_7        9'h000

// Last bit index of a word
`define CSP_LAST_8        4'h7
`define CSP_LAST_16       4'hf
`endif

// [rtl/csp_pkg.sv]
package csp_pkg;

    typedef enum logic [1:0] {
        CSP_OP_8BIT  = 2'b00,
        CSP_OP_16BIT = 2'b01,
        CSP_OP_CONT  = 2'b10,
        CSP_OP_RSVD  = 2'b11
    } csp_op_t;

    typedef struct packed {
        csp_op_t    op_mode;
        logic [1:0] spare;
        logic       clock_source_sel;
        logic [2:0] prescale_sel;
    } csp_mode_t;

    typedef enum logic [1:0] {
        CSP_ST_IDLE  = 2'b00,
        CSP_ST_SHIFT = 2'b01,
        CSP_ST_CONT  = 2'b10
    } csp_state_t;

    typedef struct packed {
        logic o;
        logic oe;
    } csp_drive_t;

endpackage

// [rtl/csp_prescaler.sv]
`timescale 1ns/1ns
`include "csp_defs.svh"
module csp_prescaler
    import csp_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);

    logic [8:0] cnt_q;
    logic [8:0] half;

    // R1: divisor decode
    always_comb begin
        unique case (sel)
            3'h0: half = `CSP_HALF_0;
            3'h1: half = `CSP_HALF_1;
            3'h2: half = `CSP_HALF_2;
            3'h3: half = `CSP_HALF_3;
            3'h4: half = `CSP_HALF_4;
            3'h5: half = `CSP_HALF_5;
            3'h6: half = `CSP_HALF_6;
            3'h7: half = `CSP_HALF_7;
        endcase
    end

    // Count restarts whenever the port is idle so the first edge is a full half period away
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 9'h000;
        end else if (!run || cnt_q >= half) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    assign tick = run && (cnt_q >= half);

endmodule

// [rtl/csp_top.sv]
`timescale 1ns/1ns
`include "csp_defs.svh"
module csp_top
    import csp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        si_i,
    output logic             so_o,
    output logic             irq
);

    // Bus side
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic        rd_wait_q;
    logic [7:0]  addr_q;
    logic [31:0] hrdata_q;
    logic        addr_ok;
    logic        bus_wr;
    logic [7:0]  wbyte;

    // Registers
    csp_mode_t   mode_q;
    logic [7:0]  data_hi_q;
    logic [7:0]  data_lo_q;
    logic [1:0]  stat_q;
    logic [1:0]  ien_q;
    logic [31:0] rd_mux;

    // Serial engine
    csp_state_t  state_q;
    logic [15:0] shreg_q;
    logic [3:0]  bitcnt_q;
    logic        sck_q;
    logic        so_q;
    logic        done_q;
    logic        start_req;
    logic        coll_evt;
    logic        presc_tick;
    logic        sck_s1_q;
    logic        sck_s2_q;
    logic        sck_s3_q;
    logic        si_s1_q;
    logic        si_s2_q;
    logic        ext_src;
    logic        sixteen;
    logic        fall_evt;
    logic        rise_evt;
    logic [3:0]  last_bit;
    csp_drive_t  sck_drv;

    assign addr_ok = hsel && htrans[1] && hready;
    assign bus_wr  = wr_pend_q;
    assign wbyte   = hwdata[7:0];

    // Address phase capture; a read gets one wait state so it sees the
    // effect of a write whose data phase overlaps its address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else if (hreadyout) begin
            wr_pend_q <= addr_ok && hwrite;
            rd_pend_q <= addr_ok && !hwrite;
            if (addr_ok) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_q <= 1'b0;
            hrdata_q  <= 32'h0000_0000;
        end else if (rd_pend_q && !rd_wait_q) begin
            rd_wait_q <= 1'b1;
            hrdata_q  <= rd_mux;
        end else begin
            rd_wait_q <= 1'b0;
        end
    end

    assign hreadyout = !(rd_pend_q && !rd_wait_q);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Unmapped and write-only offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_q)
            `CSP_OFS_MODE:    rd_mux[7:0] = mode_q;
            `CSP_OFS_DATA_HI: rd_mux[7:0] = data_hi_q;
            `CSP_OFS_DATA_LO: rd_mux[7:0] = data_lo_q;
            `CSP_OFS_CTRL: begin
                rd_mux[`CSP_CTRL_START] = (state_q == CSP_ST_SHIFT);
                rd_mux[`CSP_CTRL_SO_HIGH] = so_q;
                rd_mux[11:8]            = bitcnt_q;
            end
            `CSP_OFS_STAT:    rd_mux[1:0] = stat_q;
            `CSP_OFS_IEN:     rd_mux[1:0] = ien_q;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // R4: mode field is plain storage; reserved code 11 simply idles the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= `CSP_MODE_RST;
        end else if (bus_wr && addr_q == `CSP_OFS_MODE) begin
            mode_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ien_q <= `CSP_IEN_RST;
        end else if (bus_wr && addr_q == `CSP_OFS_IEN) begin
            ien_q <= hwdata[1:0];
        end
    end

    assign start_req = bus_wr && addr_q == `CSP_OFS_CTRL && wbyte[`CSP_CTRL_START];
    assign coll_evt  = bus_wr && (state_q == CSP_ST_SHIFT)
                       && (addr_q == `CSP_OFS_DATA_HI || addr_q == `CSP_OFS_DATA_LO
                           || addr_q == `CSP_OFS_MODE);

    // R5: data bytes carry no reset; writes during a transfer are dropped and
    // flagged, since the shifter owns the word until it completes.
    always_ff @(posedge hclk) begin
        if (done_q) begin
            // R7: upper byte is bits 15 to 8
            if (sixteen) begin
                data_hi_q <= shreg_q[15:8];
            end
            // R6: 8-bit mode leaves the upper byte alone
            data_lo_q <= shreg_q[7:0];
        end else if (bus_wr && state_q != CSP_ST_SHIFT) begin
            if (addr_q == `CSP_OFS_DATA_HI) begin
                data_hi_q <= wbyte;
            end
            if (addr_q == `CSP_OFS_DATA_LO) begin
                data_lo_q <= wbyte;
            end
        end
    end

    // R8: sticky flags, cleared by a zero on the status offset or a one on the
    // clear offset; a new event in the same cycle wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= `CSP_STAT_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (bus_wr && addr_q == `CSP_OFS_STAT && !hwdata[i]) begin
                    stat_q[i] <= 1'b0;
                end
                if (bus_wr && addr_q == `CSP_OFS_CLR && hwdata[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
            if (done_q) begin
                stat_q[`CSP_ST_DONE] <= 1'b1;
            end
            if (coll_evt) begin
                stat_q[`CSP_ST_COLL] <= 1'b1;
            end
        end
    end

    assign irq = |(stat_q & ien_q);

    // Pin synchronisers; the second stage feeds logic, and the clock's third stage also feeds its edge detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
            si_s1_q  <= 1'b0;
            si_s2_q  <= 1'b0;
        end else begin
            sck_s1_q <= sck_i;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            si_s1_q  <= si_i;
            si_s2_q  <= si_s1_q;
        end
    end

    assign ext_src  = mode_q.clock_source_sel;
    assign sixteen  = (mode_q.op_mode == CSP_OP_16BIT);
    assign last_bit = sixteen ? `CSP_LAST_16 : `CSP_LAST_8;

    csp_prescaler u_presc (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (state_q != CSP_ST_IDLE && !ext_src),
        .sel     (mode_q.prescale_sel),
        .tick    (presc_tick)
    );

    // R3: external clock edges come from the synchronised pin
    // R2: internal edges come from the prescaler toggling the driven clock
    assign fall_evt = ext_src ? (!sck_s2_q && sck_s3_q) : (presc_tick && sck_q);
    assign rise_evt = ext_src ? (sck_s2_q && !sck_s3_q) : (presc_tick && !sck_q);

    // Transfer sequencer: data changes on the falling edge, samples on the rising
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= CSP_ST_IDLE;
            bitcnt_q <= 4'h0;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                CSP_ST_IDLE: begin
                    bitcnt_q <= 4'h0;
                    if (mode_q.op_mode == CSP_OP_CONT && !ext_src) begin
                        state_q <= CSP_ST_CONT;
                    end else if (start_req && !mode_q.op_mode[1]) begin
                        state_q <= CSP_ST_SHIFT;
                    end
                end
                CSP_ST_SHIFT: begin
                    if (rise_evt) begin
                        bitcnt_q <= bitcnt_q + 4'h1;
                        if (bitcnt_q == last_bit) begin
                            state_q <= CSP_ST_IDLE;
                            done_q  <= 1'b1;
                        end
                    end
                end
                // R10: free-running clock until the mode is changed
                CSP_ST_CONT: begin
                    if (mode_q.op_mode != CSP_OP_CONT || ext_src) begin
                        state_q <= CSP_ST_IDLE;
                    end
                end
                default: state_q <= CSP_ST_IDLE;
            endcase
        end
    end

    // Shift register; least significant bit goes out first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shreg_q <= 16'h0000;
        end else if (state_q == CSP_ST_IDLE && start_req) begin
            shreg_q <= {data_hi_q, data_lo_q};
        end else if (state_q == CSP_ST_SHIFT && rise_evt) begin
            if (sixteen) begin
                shreg_q <= {si_s2_q, shreg_q[15:1]};
            end else begin
                shreg_q <= {8'h00, si_s2_q, shreg_q[7:1]};
            end
        end
    end

    // Internal clock rests high between words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_q <= 1'b1;
        end else if (state_q == CSP_ST_IDLE || ext_src) begin
            sck_q <= 1'b1;
        end else if (presc_tick) begin
            sck_q <= !sck_q;
        end
    end

    // Data output holds the last bit after a word, as the far side may still sample it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            so_q <= 1'b1;
        end else if (state_q == CSP_ST_SHIFT && fall_evt) begin
            so_q <= shreg_q[0];
        end else if (bus_wr && addr_q == `CSP_OFS_CTRL && wbyte[`CSP_CTRL_SO_HIGH]
                     && state_q != CSP_ST_SHIFT) begin
            // R9: forced high level
            so_q <= 1'b1;
        end
    end

    // R2: drive the clock pin only with the internal source
    assign sck_drv.o  = sck_q;
    assign sck_drv.oe = !ext_src;
    assign sck_o      = sck_drv.o;
    assign sck_oe     = sck_drv.oe;
    assign so_o       = so_q;

    // hsize is single-word only on this bus; not decoded
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8], hwdata[31:8], htrans[0]};

endmodule

// [testbench/csp_asserts.sv]
`timescale 1ns/1ns
module csp_asserts
    import csp_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        sck_o,
    input wire logic        sck_oe,
    input wire logic        irq
);
    logic take;
    logic rd_q;
    logic wr_q;
    logic wrm_q;
    assign take = hsel & htrans[1] & hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            wrm_q <= 1'b0;
        end else begin
            rd_q  <= take & !hwrite;
            wr_q  <= take & hwrite;
            wrm_q <= take & hwrite & (haddr[7:0] == 8'h00);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_read_wait;
        take && !hwrite |=> s_wait;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read did not wait exactly one cycle");
    property p_write_fast;
        take && hwrite |=> hreadyout;
    endproperty
    a_write_fast: assert property (p_write_fast)
        else $error("write was stalled");
    property p_wait_cause;
        !hreadyout |-> rd_q;
    endproperty
    a_wait_cause: assert property (p_wait_cause)
        else $error("wait state outside a read");
    property p_resp;
        hresp == 1'b0;
    endproperty
    a_resp: assert property (p_resp)
        else $error("response not okay");
    property p_hrdata;
        $changed(hrdata) |-> $past(rd_q);
    endproperty
    a_hrdata: assert property (p_hrdata)
        else $error("read data moved without a read");
    property p_oe_mode;
        $changed(sck_oe) |-> $past(wrm_q);
    endproperty
    a_oe_mode: assert property (p_oe_mode)
        else $error("clock pin direction changed without a mode write");
    property p_ext_hold;
        !sck_oe && $past(!sck_oe) |-> $stable(sck_o);
    endproperty
    a_ext_hold: assert property (p_ext_hold)
        else $error("clock output moved while pin is an input");
    property p_irq_fall;
        $fell(irq) |-> $past(wr_q);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a write");
endmodule

bind csp_top csp_asserts i_csp_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .sck_o, .sck_oe, .irq);

// [testbench/csp_serial_dev.sv]
`timescale 1ns/1ns
module csp_serial_dev (
    input  wire logic        sck,
    input  wire logic        so,
    input  wire logic        load,
    input  wire logic [15:0] tx_word,
    input  wire logic        ext_go,
    input  wire logic [4:0]  ext_cycles,
    output logic             si,
    output logic             ext_clk,
    output logic [15:0]      rx_word
);
    logic [15:0] tx_q;
    initial begin
        si      = 1'b0;
        ext_clk = 1'b1;
        rx_word = 16'h0000;
        tx_q    = 16'h0000;
    end
    always @(posedge load) begin
        tx_q = tx_word;
    end
    // clock from this side, resting high; mid-cycle edges avoid races
    always @(posedge ext_go) begin
        #5;
        repeat (ext_cycles) begin
            #80 ext_clk = 1'b0;
            #80 ext_clk = 1'b1;
        end
    end
    // next bit on falling edge, LSB first; past the word the line keeps changing
    always @(negedge sck) begin
        si   = tx_q[0];
        tx_q = {~tx_q[0], tx_q[15:1]};
    end
    always @(posedge sck) begin
        rx_word = {so, rx_word[15:1]};
    end
endmodule

// [testbench/csp_tb_top.sv]
`timescale 1ns/1ns
module csp_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hreadyout, hresp, sck_o, sck_oe, so_o, irq;
    logic        si, ext_clk, load, ext_go, sck_pin;
    logic [1:0]  htrans;
    logic [4:0]  ext_cycles;
    logic [15:0] tx_word, rx_word;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          fails, comparisons;
    assign sck_pin = sck_oe ? sck_o : ext_clk;
    always #5 hclk = ~hclk;
    csp_top i_csp_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sck_i(sck_pin), .sck_o,
        .sck_oe, .si_i(si), .so_o, .irq);
    csp_serial_dev i_csp_serial_dev (.sck(sck_pin), .so(so_o), .load, .tx_word, .ext_go,
        .ext_cycles, .si, .ext_clk, .rx_word);
    task automatic complete_run;
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Samples at the falling edge so the rising edge sees the same settled value
    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            $display("Error at %0t: bus hang", $time);
            fails++;
            complete_run();
        end
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Mask order: so_o, sck_oe, sck_o, irq
    task automatic pinchk(input logic [3:0] m, input logic [3:0] exp);
        @(negedge hclk);
        chk({28'h0, m & {so_o, sck_oe, sck_o, irq}}, {28'h0, exp});
        @(posedge hclk);
    endtask
    task automatic start(input logic [15:0] tx, input logic ext);
        tx_word <= tx;
        load    <= 1'b1;
        ext_go  <= ext;
        bus(1'b1, 8'h0c, 32'h1);
        load    <= 1'b0;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h0c, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 500);
        if (rd[0] !== 1'b0) begin
            $display("Error at %0t: transfer never ended", $time);
            fails++;
            complete_run();
        end
        ext_go <= 1'b0;
    endtask
    task automatic t_reset;
        rdchk(8'h00, 32'h0);
        rdchk(8'h10, 32'h0);
        rdchk(8'h18, 32'h0);
        bus(1'b1, 8'h1c, 32'hff);
        rdchk(8'h1c, 32'h0);
        pinchk(4'hf, 4'he);
        $display("t_reset done");
    endtask
    task automatic t_data;
        bus(1'b1, 8'h04, 32'h5a);
        bus(1'b1, 8'h08, 32'hc3);
        rdchk(8'h04, 32'h5a);
        rdchk(8'h08, 32'hc3);
        $display("t_data done");
    endtask
    task automatic t_xfer8;
        bus(1'b1, 8'h00, 32'h04);
        bus(1'b1, 8'h04, 32'ha5);
        bus(1'b1, 8'h08, 32'h3c);
        bus(1'b1, 8'h18, 32'h1);
        start(16'h00c9, 1'b0);
        wait_idle();
        rdchk(8'h08, 32'hc9);
        rdchk(8'h04, 32'ha5);
        chk({24'h0, rx_word[15:8]}, 32'h3c);
        bus(1'b1, 8'h10, 32'h3);
        rdchk(8'h10, 32'h1);
        pinchk(4'h1, 4'h1);
        bus(1'b1, 8'h10, 32'h0);
        rdchk(8'h10, 32'h0);
        pinchk(4'h1, 4'h0);
        bus(1'b1, 8'h0c, 32'h10);
        pinchk(4'h8, 4'h8);
        $display("t_xfer8 done");
    endtask
    task automatic t_xfer16;
        bus(1'b1, 8'h00, 32'h44);
        bus(1'b1, 8'h04, 32'h12);
        bus(1'b1, 8'h08, 32'h34);
        start(16'hbeef, 1'b0);
        bus(1'b1, 8'h08, 32'h77);
        wait_idle();
        rdchk(8'h04, 32'hbe);
        rdchk(8'h08, 32'hef);
        chk({16'h0, rx_word}, 32'h1234);
        rdchk(8'h10, 32'h3);
        pinchk(4'h1, 4'h1);
        bus(1'b1, 8'h18, 32'h0);
        pinchk(4'h1, 4'h0);
        bus(1'b1, 8'h14, 32'h3);
        rdchk(8'h10, 32'h0);
        bus(1'b1, 8'h00, 32'hc0);
        bus(1'b1, 8'h0c, 32'h1);
        rdchk(8'h0c, 32'h0);
        $display("t_xfer16 done");
    endtask
    task automatic t_ext;
        bus(1'b1, 8'h00, 32'h08);
        pinchk(4'h4, 4'h0);
        bus(1'b1, 8'h08, 32'h5a);
        start(16'h0096, 1'b1);
        wait_idle();
        rdchk(8'h08, 32'h96);
        chk({24'h0, rx_word[15:8]}, 32'h5a);
        $display("t_ext done");
    endtask
    task automatic t_cont;
        int   half [8] = '{512, 128, 32, 16, 8, 4, 2, 1};
        int   n;
        logic prev;
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 8'h00, 32'h80 | c);
            n = 0;
            do begin
                prev = sck_o;
                @(negedge hclk);
                n++;
            end while (!(prev === 1'b1 && sck_o === 1'b0) && n < 2200);
            n = 0;
            while (sck_o === 1'b0 && n < 600) begin
                n++;
                @(negedge hclk);
            end
            @(posedge hclk);
            chk(n, half[c]);
        end
        bus(1'b1, 8'h00, 32'h0);
        $display("t_cont done");
    endtask
    initial begin
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hwdata      = 32'h0;
        load        = 1'b0;
        ext_go      = 1'b0;
        ext_cycles  = 5'h08;
        tx_word     = 16'h0;
        fails       = 0;
        comparisons = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_data();
        t_xfer8();
        t_xfer16();
        t_ext();
        t_cont();
        complete_run();
    end
endmodule
